// >>> rtl/adcsp_consts.svh
// Constants for the serial conversion port
`ifndef ADCSP_CONSTS_SVH
`define ADCSP_CONSTS_SVH
`define ADCSP_CFG_BITS 14
`define ADCSP_RES_BITS 16
`define ADCSP_CFG_RESET 14'h3fff
`define ADCSP_ECHO_BIT 0
`define ADCSP_END_PLAIN 16
`define ADCSP_END_PLAIN_ECHO 30
`define ADCSP_END_BUSY 17
`define ADCSP_END_BUSY_ECHO 31
`define ADCSP_CONV_TIME_NS 1600
`define ADCSP_CLK_PERIOD_NS 5
`define ADCSP_CONV_CYCLES \
    ((`ADCSP_CONV_TIME_NS + `ADCSP_CLK_PERIOD_NS - 1) / `ADCSP_CLK_PERIOD_NS)
`endif

// >>> rtl/adcsp_pkg.sv
// Types for the serial conversion port
package adcsp_pkg;
    typedef enum logic [2:0] {
        ADCSP_ACQ = 3'b001,
        ADCSP_CONV = 3'b010,
        ADCSP_DONE = 3'b100
    } adcsp_state_t;
endpackage

// >>> rtl/adcsp_port.sv
// Serial conversion and configuration port, device side
`timescale 1ns/1ps
`include "adcsp_consts.svh"
module adcsp_port
    import adcsp_pkg::*;
#(
    parameter int CONV_CYCLES = `ADCSP_CONV_CYCLES
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic conversion_start,
    input wire logic serial_clk,
    input wire logic serial_in,
    input wire logic [15:0] sample_value,
    output logic serial_out,
    output logic serial_out_oe,
    output logic core_power,
    output logic [13:0] config_word,
    output logic config_load
);
    // Counter is 16 bits wide, so longer conversions cannot be served
    if (CONV_CYCLES < 1 || CONV_CYCLES > 65535) begin : g_conv_chk
        $error("CONV_CYCLES out of range");
    end

    // ----------------------------------------------------------
    // Input synchronisation
    // ----------------------------------------------------------
    logic cs_lvl, cs_rise, cs_fall;
    logic sck_rise, sck_fall;
    logic din_lvl;
    adcsp_sync u_cs (.clk(clk), .rst_b(rst_b), .async_in(conversion_start),
        .level(cs_lvl), .rise(cs_rise), .fall(cs_fall));
    adcsp_sync u_sck (.clk(clk), .rst_b(rst_b), .async_in(serial_clk),
        .level(), .rise(sck_rise), .fall(sck_fall));
    adcsp_sync u_din (.clk(clk), .rst_b(rst_b), .async_in(serial_in),
        .level(din_lvl), .rise(), .fall());

    // ----------------------------------------------------------
    // Conversion sequencing
    // ----------------------------------------------------------
    adcsp_state_t state;
    logic [15:0] conv_cnt;
    logic [15:0] result;
    logic [13:0] result_cfg;
    logic busy_mode;
    wire conv_last = (conv_cnt == 16'(CONV_CYCLES - 1));
    wire eoc = (state == ADCSP_CONV) && conv_last;
    wire start = cs_rise;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= ADCSP_ACQ;
            conv_cnt <= 16'h0000;
        end else begin
            case (state)
                ADCSP_ACQ, ADCSP_DONE: begin
                    conv_cnt <= 16'h0000;
                    if (start) begin
                        state <= ADCSP_CONV;
                    end
                end
                ADCSP_CONV: begin
                    // Start level ignored until count expires
                    conv_cnt <= conv_cnt + 16'h0001;
                    if (conv_last) begin
                        state <= ADCSP_DONE;
                    end
                end
                default: state <= ADCSP_ACQ;
            endcase
        end
    end
    assign core_power = (state == ADCSP_CONV);

    // ----------------------------------------------------------
    // Configuration shift-in
    // ----------------------------------------------------------
    logic [13:0] cfg_shift;
    logic [3:0] cfg_cnt;
    logic [13:0] cfg_pending;
    logic pending;
    wire cfg_take = ~cs_lvl && sck_rise && (cfg_cnt < 4'd14)
        && !start;
    wire cfg_full = cfg_take && (cfg_cnt == 4'd13);

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cfg_shift <= 14'h0000;
            cfg_cnt <= 4'h0;
            cfg_pending <= `ADCSP_CFG_RESET;
            pending <= 1'b0;
            config_word <= `ADCSP_CFG_RESET;
            config_load <= 1'b0;
        end else begin
            config_load <= 1'b0;
            if (start || eoc) begin
                // Partial word dropped here
                cfg_cnt <= 4'h0;
            end else if (cfg_take) begin
                cfg_shift <= {cfg_shift[12:0], din_lvl};
                cfg_cnt <= cfg_cnt + 4'h1;
            end
            if (cfg_full && !eoc) begin
                cfg_pending <= {cfg_shift[12:0], din_lvl};
                pending <= 1'b1;
            end
            // Word takes effect at the next end of conversion
            if (eoc && pending) begin
                config_word <= cfg_pending;
                config_load <= 1'b1;
                pending <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------
    // Result shift-out
    // ----------------------------------------------------------
    logic [29:0] out_shift;
    logic [4:0] fall_cnt;
    wire echo = ~result_cfg[`ADCSP_ECHO_BIT];
    wire [4:0] end_plain = echo ? 5'd30 : 5'd16;
    wire [4:0] end_busy = echo ? 5'd31 : 5'd17;
    wire [4:0] end_cnt = busy_mode ? end_busy : end_plain;
    wire last_fall = sck_fall && (fall_cnt == end_cnt - 5'd1);
    wire in_read = (state == ADCSP_DONE) && serial_out_oe;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            result <= 16'h0000;
            result_cfg <= `ADCSP_CFG_RESET;
            busy_mode <= 1'b0;
            out_shift <= 30'h0000_0000;
            fall_cnt <= 5'h00;
            serial_out <= 1'b0;
            serial_out_oe <= 1'b0;
        end else if (start) begin
            serial_out_oe <= 1'b0;
            fall_cnt <= 5'h00;
        end else if (eoc) begin
            result <= sample_value;
            result_cfg <= config_word;
            busy_mode <= ~cs_lvl;
            // Newer result overwrites unread one
            out_shift <= {sample_value[14:0], config_word, 1'b0};
            fall_cnt <= 5'h00;
            if (!cs_lvl) begin
                serial_out <= 1'b0;
                serial_out_oe <= 1'b1;
            end else begin
                serial_out_oe <= 1'b0;
            end
        end else if (state == ADCSP_DONE) begin
            if (!busy_mode && cs_fall && fall_cnt == 5'h00) begin
                serial_out <= result[15];
                serial_out_oe <= 1'b1;
            end else if (!busy_mode && cs_lvl) begin
                serial_out_oe <= 1'b0;
            end else if (sck_fall && ~cs_lvl && in_read
                    && fall_cnt < end_cnt) begin
                // Bit changes only on falls, stable over rise
                fall_cnt <= fall_cnt + 5'h01;
                if (last_fall) begin
                    serial_out_oe <= 1'b0;
                end else if (busy_mode && fall_cnt == 5'h00) begin
                    serial_out <= result[15];
                end else begin
                    // Echo follows result LSB
                    serial_out <= busy_mode ? out_shift[30 - 1 -
                        5'(fall_cnt - 5'd1)] :
                        out_shift[29 - 5'(fall_cnt)];
                end
            end
        end
    end
endmodule

// >>> rtl/adcsp_sync.sv
// Two-flop synchroniser with edge outputs
`timescale 1ns/1ps
module adcsp_sync (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic async_in,
    output logic level,
    output logic rise,
    output logic fall
);
    logic meta;
    logic prev;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            meta <= 1'b0;
            level <= 1'b0;
            prev <= 1'b0;
        end else begin
            meta <= async_in;
            level <= meta;
            prev <= level;
        end
    end
    assign rise = level & ~prev;
    assign fall = ~level & prev;
endmodule

// >>> test/adcsp_host.sv
// Host controller model for the serial conversion port
`timescale 1ns/1ps
module adcsp_host (
    output logic conversion_start,
    output logic serial_clk,
    output logic serial_in,
    input logic serial_out
);
    initial begin
        conversion_start = 1'b0;
        serial_clk = 1'b0;
        serial_in = 1'b0;
    end
    task start(input logic busy);
        conversion_start = 1'b0;
        #30 conversion_start = 1'b1;
        serial_clk = busy;
        #40 conversion_start = !busy;
    endtask
    task sel(input logic v);
        conversion_start = v;
        #60;
    endtask
    // Idle data toggles so a stale level is never mistaken for data
    task xfer(input logic cpol, input int n, input logic [13:0] cfg,
        input int nc, output logic [29:0] rx);
        #3.3;
        for (int i = 0; i < n; i++) begin
            if (cpol) serial_clk = 1'b0;
            serial_in = (i < nc) ? cfg[nc-1-i] : !serial_in;
            #32 serial_clk = 1'b1;
            rx = {rx[28:0], serial_out};
            #32 if (!cpol) serial_clk = 1'b0;
        end
        #32 serial_in = !serial_in;
    endtask
endmodule

// >>> test/adcsp_port_sva.sv
// Pin-level assertions for the serial conversion port
`timescale 1ns/1ps
module adcsp_port_sva #(
    parameter int CONV_CYCLES = 20
) (
    input logic clk,
    input logic rst_b,
    input logic conversion_start,
    input logic serial_clk,
    input logic serial_out,
    input logic serial_out_oe,
    input logic core_power,
    input logic [13:0] config_word,
    input logic config_load
);
    localparam int CMAX = CONV_CYCLES + 2;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    sequence s_eoc; $fell(core_power); endsequence
    sequence s_busy; serial_out_oe && !serial_out; endsequence
    // Start is synchronised, so allow its flop delay
    property p_flt;
        $rose(conversion_start) |-> ##[1:6] !serial_out_oe;
    endproperty
    a_flt: assert property (p_flt) else $error("no float");
    property p_run; $rose(core_power) |-> core_power[*8] ##[1:CMAX] !core_power;
    endproperty
    a_run: assert property (p_run) else $error("conv length");
    property p_qt; s_eoc ##0 conversion_start |-> !serial_out_oe[*4]; endproperty
    a_qt: assert property (p_qt) else $error("busy shown");
    property p_bsy; s_eoc ##0 !conversion_start |-> ##[0:3] s_busy; endproperty
    a_bsy: assert property (p_bsy) else $error("no busy");
    property p_hld; $changed(config_word) |-> config_load || $past(config_load);
    endproperty
    a_hld: assert property (p_hld) else $error("cfg moved");
    property p_ld; $rose(config_load) |-> $past(core_power) ||
        $past(core_power, 2) || $past(core_power, 3); endproperty
    a_ld: assert property (p_ld) else $error("load off eoc");
    property p_acq; s_eoc |-> !core_power[*4]; endproperty
    a_acq: assert property (p_acq) else $error("core on");
    property p_stb; $rose(serial_clk) |=>
        (!serial_out_oe || $stable(serial_out))[*3]; endproperty
    a_stb: assert property (p_stb) else $error("bit moved");
endmodule
bind adcsp_port adcsp_port_sva #(.CONV_CYCLES(CONV_CYCLES)) i_sva (
    .clk(clk), .rst_b(rst_b), .conversion_start(conversion_start),
    .serial_clk(serial_clk), .serial_out(serial_out),
    .serial_out_oe(serial_out_oe), .core_power(core_power),
    .config_word(config_word), .config_load(config_load));

// >>> test/tb_adc_serial_conversion_port.sv
// Self-checking bench for the serial conversion port
`timescale 1ns/1ps
module tb_adc_serial_conversion_port;
    localparam logic [13:0] CFG = 14'h2a5a;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [15:0] sample_value = 16'h0000;
    logic conversion_start, serial_clk, serial_in, serial_out;
    logic serial_out_oe, core_power, config_load;
    logic [13:0] config_word;
    logic [29:0] rx;
    int fail_count = 0;
    int checks_done = 0;
    // Pull-up on the floated line makes the busy edge visible
    wire sdo_pin = serial_out_oe ? serial_out : 1'b1;
    always #2.5 clk = ~clk;
    adcsp_port #(.CONV_CYCLES(20)) i_dut (.clk(clk), .rst_b(rst_b),
        .conversion_start(conversion_start), .serial_clk(serial_clk),
        .serial_in(serial_in), .sample_value(sample_value),
        .serial_out(serial_out), .serial_out_oe(serial_out_oe),
        .core_power(core_power), .config_word(config_word),
        .config_load(config_load));
    adcsp_host i_host (.conversion_start(conversion_start),
        .serial_clk(serial_clk), .serial_in(serial_in), .serial_out(sdo_pin));
    task end_sim;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task check(input logic ok, input string what);
        checks_done++;
        if (ok !== 1'b1) begin
            fail_count++;
            $display("MISMATCH %0t %s", $time, what);
        end
    endtask
    task convert(input logic [15:0] s, input logic busy);
        int k;
        @(posedge clk) #1 sample_value = s;
        i_host.start(busy);
        for (k = 0; k < 99 && core_power !== 1'b0; k++) @(posedge clk);
        check(k < 99, "conversion hung");
        if (k == 99) end_sim;
        repeat (4) @(posedge clk);
        #1;
    endtask
    task t_plain;
        convert(16'h8001, 1'b0);
        check(serial_out_oe === 1'b0, "busy shown");
        i_host.sel(1'b0);
        i_host.xfer(1'b0, 16, CFG, 14, rx);
        check(rx[15:0] === 16'h8001, "plain read");
        check(serial_out_oe === 1'b0, "no float at 16");
        convert(16'h7ffe, 1'b0);
        check(config_word === CFG, "config lost");
        // Result converted under the old word carries no echo
        i_host.sel(1'b0);
        i_host.xfer(1'b0, 16, CFG, 0, rx);
        check(rx[15:0] === 16'h7ffe, "second read");
        check(serial_out_oe === 1'b0, "echo too early");
        convert(16'h6b1d, 1'b0);
        i_host.sel(1'b0);
        i_host.xfer(1'b0, 29, CFG, 14, rx);
        check(rx[28:0] === {16'h6b1d, CFG[13:1]}, "echo");
        check(serial_out_oe === 1'b1, "early float");
        i_host.xfer(1'b0, 1, CFG, 0, rx);
        check(serial_out_oe === 1'b0, "no float at 30");
        $display("plain done");
    endtask
    task t_abort;
        convert(16'hc3a5, 1'b0);
        i_host.sel(1'b0);
        i_host.xfer(1'b0, 5, 14'h0000, 5, rx);
        check(rx[4:0] === 5'h18, "partial read");
        i_host.sel(1'b1);
        check(serial_out_oe === 1'b0, "no float on start");
        convert(16'h1234, 1'b0);
        check(config_word === CFG, "partial word taken");
        $display("abort done");
    endtask
    task t_busy;
        convert(16'h5a3c, 1'b1);
        check(serial_out_oe === 1'b1 && serial_out === 1'b0, "no busy");
        i_host.xfer(1'b1, 30, CFG, 14, rx);
        check(rx === {16'h5a3c, CFG}, "busy read");
        check(serial_out_oe === 1'b1, "early float");
        i_host.xfer(1'b1, 1, CFG, 0, rx);
        check(serial_out_oe === 1'b0, "no float at 31");
        $display("busy done");
    endtask
    initial begin
        repeat (2) @(posedge clk);
        #1 rst_b = 1'b1;
        repeat (3) @(posedge clk);
        check(config_word === 14'h3fff, "reset config");
        t_plain;
        t_abort;
        t_busy;
        end_sim;
    end
endmodule
